// [hw/tkc_pkg.sv]
/*
 Constants for the time keeper control register block: field positions,
 reset value, masks and timing counts.
 Assumes a 25 MHz clock and a plain address/strobe register port.
*/
package tkc_pkg;
	localparam logic [3:0] TKC_CONTROL_ADDR = 4'h0;
	localparam int TKC_CAL_LSB = 16;
	localparam int TKC_CAL_MSB = 25;
	localparam int TKC_ON_BIT = 15;
	localparam int TKC_IDLE_BIT = 13;
	localparam int TKC_SEL_BIT = 7;
	localparam int TKC_RUN_BIT = 6;
	localparam int TKC_UNLOCK_BIT = 3;
	localparam int TKC_SYNC_BIT = 2;
	localparam int TKC_HALF_BIT = 1;
	localparam int TKC_OE_BIT = 0;
	localparam logic [31:0] TKC_RESET = 32'h0000_0000;
	// Bits software may write directly (cal, idle, sel, oe; on only while unlock is set)
	localparam logic [31:0] TKC_WMASK = 32'h03ff_a081;
	// Clock rate and the one-second tick of the module clock
	localparam int TKC_CLK_HZ = 25000000;
	localparam int TKC_SEC_S = 1;
	localparam int TKC_SEC_CYC = TKC_CLK_HZ * TKC_SEC_S;
	localparam int TKC_MIN_SECONDS = 60;
	localparam logic [9:0] TKC_CAL_MIN = 10'h200;
endpackage

// [hw/tkc_tick.sv]
/*
 Divider that produces the module's second tick from the gated clock
 enable, with per-minute drift correction of the tick count.
 Assumes run_en high in every cycle the module clock is active.
*/
`timescale 1ns/1ps
module tkc_tick #(
	parameter int SEC_CYC = tkc_pkg::TKC_SEC_CYC
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic run_en,
	input wire logic [9:0] cal,
	output logic sec_tick,
	output logic half_tick
);
	logic [31:0] cnt_reg;
	logic [5:0] sec_reg;
	logic [31:0] limit;
	logic [31:0] cal_ext;
	logic minute_end;

	// Signed calibration stretches or trims the last second of each minute
	assign cal_ext = {{22{cal[9]}}, cal};
	assign minute_end = (sec_reg == 6'(tkc_pkg::TKC_MIN_SECONDS - 1));
	assign limit = minute_end ? 32'(SEC_CYC) + cal_ext - 32'h1 :
		32'(SEC_CYC) - 32'h1;
	assign sec_tick = run_en && (cnt_reg >= limit);
	assign half_tick = run_en && (cnt_reg == 32'(SEC_CYC / 2) - 32'h1);

	// Cycle count within the second
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			cnt_reg <= 32'h0;
		else if (sec_tick)
			cnt_reg <= 32'h0;
		else if (run_en)
			cnt_reg <= cnt_reg + 32'h1;
	end

	// Second count within the minute
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			sec_reg <= 6'h0;
		else if (sec_tick)
			sec_reg <= minute_end ? 6'h0 : sec_reg + 6'h1;
	end
endmodule

// [hw/tkc_sync.sv]
/*
 Two flip-flop synchroniser for one level from outside the clock domain.
 Assumes the level is stable for several clock cycles.
*/
`timescale 1ns/1ps
module tkc_sync (
	input wire logic clock,
	input wire logic resetn,
	input wire logic din,
	output logic dout
);
	logic meta_reg;

	// First stage feeds only the second
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_reg <= 1'b0;
			dout <= 1'b0;
		end
		else
		begin
			meta_reg <= din;
			dout <= meta_reg;
		end
	end
endmodule

// [hw/tkc_control.sv]
/*
 Control and status register of the time keeper module with the seconds
 and alarm pin output, halt in idle and write unlock gating.
 Assumes resetn is the power-on reset only; other resets are not wired
 here. cpu_idle and unlock_seq are async pins; seconds_write and
 alarm_pulse are one-cycle pulses from logic on the same clock.
*/
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
module tkc_control #(
	parameter int SEC_CYC = tkc_pkg::TKC_SEC_CYC
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic cpu_idle,
	input wire logic unlock_seq,
	input wire logic seconds_write,
	input wire logic alarm_pulse,
	output logic pin_out,
	output logic pin_oe,
	output logic module_clk_en,
	output logic second_pulse
);
	logic [31:0] ctrl_reg;
	logic [31:0] ctrl_next;
	logic half_reg;
	logic run_reg;
	logic sync_reg;
	logic half_level_reg;
	logic idle_s;
	logic unlock_s;
	logic sel_hit;
	logic wr_hit;
	logic unlock_next;
	logic on_next;
	logic gate_en;
	logic sec_tick;
	logic half_tick;
	logic src;
	logic [31:0] status_word;

	// Pin inputs pass two flip-flops
	tkc_sync u_idle_sync (
		.clock(clock),
		.resetn(resetn),
		.din(cpu_idle),
		.dout(idle_s)
	);
	tkc_sync u_unlock_sync (
		.clock(clock),
		.resetn(resetn),
		.din(unlock_seq),
		.dout(unlock_s)
	);

	// Address decode
	assign sel_hit = (addr == tkc_pkg::TKC_CONTROL_ADDR);
	assign wr_hit = wr && sel_hit;

	// Unlock bit may only be set while the sequence runs
	assign unlock_next = wdata[tkc_pkg::TKC_UNLOCK_BIT] && unlock_s;
	// On bit takes the written value only while unlock currently reads one
	assign on_next = ctrl_reg[tkc_pkg::TKC_UNLOCK_BIT] ?
		wdata[tkc_pkg::TKC_ON_BIT] :
		ctrl_reg[tkc_pkg::TKC_ON_BIT];

	// Next control value; read-only and unused bits stay clear
	always_comb
	begin
		ctrl_next = ctrl_reg;
		if (wr_hit)
		begin
			ctrl_next = wdata & tkc_pkg::TKC_WMASK;
			ctrl_next[tkc_pkg::TKC_ON_BIT] = on_next;
			ctrl_next[tkc_pkg::TKC_UNLOCK_BIT] = unlock_next;
		end
	end

	// Control register, cleared only by power-on reset
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			ctrl_reg <= tkc_pkg::TKC_RESET;
		else
			ctrl_reg <= ctrl_next;
	end

	// Module clock gating: on and not halted in idle
	assign gate_en = ctrl_reg[tkc_pkg::TKC_ON_BIT] &&
		!(ctrl_reg[tkc_pkg::TKC_IDLE_BIT] && idle_s);

	tkc_tick #(
		.SEC_CYC(SEC_CYC)
	) u_tick (
		.clock(clock),
		.resetn(resetn),
		.run_en(gate_en),
		.cal(ctrl_reg[tkc_pkg::TKC_CAL_MSB:tkc_pkg::TKC_CAL_LSB]),
		.sec_tick(sec_tick),
		.half_tick(half_tick)
	);

	// Status: running, sync near rollover, half-second flag
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			run_reg <= 1'b0;
			sync_reg <= 1'b0;
			half_reg <= 1'b0;
			half_level_reg <= 1'b0;
		end
		else
		begin
			run_reg <= gate_en;
			sync_reg <= half_level_reg && gate_en;
			if (sec_tick)
				half_level_reg <= 1'b0;
			else if (half_tick)
				half_level_reg <= 1'b1;
			if (seconds_write)
				half_reg <= 1'b0;
			else if (sec_tick)
				half_reg <= 1'b0;
			else if (half_tick)
				half_reg <= 1'b1;
		end
	end

	// Read word assembly
	always_comb
	begin
		status_word = ctrl_reg;
		status_word[tkc_pkg::TKC_RUN_BIT] = run_reg;
		status_word[tkc_pkg::TKC_SYNC_BIT] = sync_reg;
		status_word[tkc_pkg::TKC_HALF_BIT] = half_reg;
	end

	// Read data stands one cycle after the strobe; zero elsewhere
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			rdata <= 32'h0;
		else if (rd && sel_hit)
			rdata <= status_word;
		else
			rdata <= 32'h0;
	end

	// Pin source selection and enable
	assign src = ctrl_reg[tkc_pkg::TKC_SEL_BIT] ? half_level_reg :
		alarm_pulse;
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			pin_out <= 1'b0;
			pin_oe <= 1'b0;
			module_clk_en <= 1'b0;
			second_pulse <= 1'b0;
		end
		else
		begin
			pin_out <= ctrl_reg[tkc_pkg::TKC_OE_BIT] && src;
			pin_oe <= ctrl_reg[tkc_pkg::TKC_OE_BIT];
			module_clk_en <= gate_en;
			second_pulse <= sec_tick;
		end
	end

	// Checks on the register behaviour
	unlock_gate_a: assert property (@(posedge clock) disable iff (!resetn)
		(wr_hit && !unlock_s) |=> !ctrl_reg[tkc_pkg::TKC_UNLOCK_BIT])
		else $error("unlock bit set outside sequence");
	on_locked_a: assert property (@(posedge clock) disable iff (!resetn)
		(!ctrl_reg[tkc_pkg::TKC_UNLOCK_BIT]) |=>
		$stable(ctrl_reg[tkc_pkg::TKC_ON_BIT]))
		else $error("on bit changed while locked");
	unused_zero_a: assert property (@(posedge clock) disable iff (!resetn)
		rd && sel_hit |=> (rdata & 32'hfc00_5f30) == 32'h0)
		else $error("unimplemented bit read nonzero");
	idle_halt_a: assert property (@(posedge clock) disable iff (!resetn)
		(ctrl_reg[tkc_pkg::TKC_IDLE_BIT] && idle_s) |-> !gate_en)
		else $error("module clock runs in idle");
	pin_enable_a: assert property (@(posedge clock) disable iff (!resetn)
		!ctrl_reg[tkc_pkg::TKC_OE_BIT] |=> !pin_out)
		else $error("pin driven while disabled");
	pin_alarm_a: assert property (@(posedge clock) disable iff (!resetn)
		(ctrl_reg[tkc_pkg::TKC_OE_BIT] && !ctrl_reg[tkc_pkg::TKC_SEL_BIT]
		&& alarm_pulse) |=> pin_out)
		else $error("alarm pulse not on pin");
	run_status_a: assert property (@(posedge clock) disable iff (!resetn)
		rd && sel_hit |=> rdata[tkc_pkg::TKC_RUN_BIT] == $past(run_reg))
		else $error("running flag wrong");
	half_clear_a: assert property (@(posedge clock) disable iff (!resetn)
		seconds_write |=> !half_reg)
		else $error("half second flag not cleared");
	ro_ignored_a: assert property (@(posedge clock) disable iff (!resetn)
		wr_hit |=> !ctrl_reg[tkc_pkg::TKC_RUN_BIT]
		&& !ctrl_reg[tkc_pkg::TKC_HALF_BIT])
		else $error("read-only bit stored");
endmodule

// [test/test_tkc_control.sv]
/*
 Bench for the time keeper control register: register access, unlock
 gating, pin routing, idle gating, half-second flag and drift trim.
 Assumes a short SEC_CYC so that a module minute stays brief.
*/
`timescale 1ns/1ps
module test_tkc_control;
	localparam int SEC = 40;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic cpu_idle = 1'b0;
	logic unlock_seq = 1'b0;
	logic seconds_write = 1'b0;
	logic alarm_pulse = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] d;
	logic pin_out;
	logic pin_oe;
	logic module_clk_en;
	logic second_pulse;
	logic [9:0] cals [3] = '{10'h005, 10'h3fd, 10'h000};
	int fail_count = 0;
	int tests_run = 0;
	int cyc = 0;
	int c;

	// Free running bus clock
	always #20 clock = ~clock;

	tkc_control #(.SEC_CYC(SEC)) tkc_control_i (
		.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .cpu_idle(cpu_idle),
		.unlock_seq(unlock_seq), .seconds_write(seconds_write),
		.alarm_pulse(alarm_pulse), .pin_out(pin_out), .pin_oe(pin_oe),
		.module_clk_en(module_clk_en), .second_pulse(second_pulse)
	);

	// Verdict and end of run
	task automatic wrap_up;
		if (fail_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Compare one value against its expectation
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	// One-cycle write strobe
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
		@(posedge clock);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask

	// One-cycle read strobe, data taken in the following cycle
	task automatic rd_reg(input logic [3:0] a);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		@(negedge clock);
		d = rdata;
	endtask

	// Cycles spanned by k second pulses
	task automatic secs(input int k, output int n);
		n = 0;
		repeat (k)
		begin
			do
			begin
				@(negedge clock);
				n++;
			end while (second_pulse !== 1'b1);
		end
	endtask

	// Hang guard
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			fail_count++;
			wrap_up;
		end
	end

	// Main sequence
	initial
	begin
		repeat (16) @(posedge clock);
		resetn <= 1'b1;
		rd_reg(4'h0);
		check(d, 32'h0);
		wr_reg(4'h0, 32'hffff_ffff);
		rd_reg(4'h0);
		check(d, 32'h03ff_2081);
		wr_reg(4'h5, 32'hffff_ffff);
		rd_reg(4'h5);
		check(d, 32'h0);
		wr_reg(4'h0, 32'h0000_0001);
		alarm_pulse <= 1'b1;
		repeat (3) @(negedge clock);
		check({30'h0, pin_oe, pin_out}, 32'h3);
		wr_reg(4'h0, 32'h0);
		repeat (3) @(negedge clock);
		check({30'h0, pin_oe, pin_out}, 32'h0);
		@(posedge clock);
		alarm_pulse <= 1'b0;
		unlock_seq <= 1'b1;
		repeat (3) @(posedge clock);
		wr_reg(4'h0, 32'h0000_0008);
		wr_reg(4'h0, 32'h0000_8008);
		repeat (2) @(posedge clock);
		rd_reg(4'h0);
		check(d & ~32'h6, 32'h0000_8048);
		wr_reg(4'h0, 32'h0000_a008);
		cpu_idle <= 1'b1;
		repeat (5) @(negedge clock);
		check({31'h0, module_clk_en}, 32'h0);
		rd_reg(4'h0);
		check(d & ~32'h6, 32'h0000_a008);
		@(posedge clock);
		cpu_idle <= 1'b0;
		repeat (5) @(negedge clock);
		check({31'h0, module_clk_en}, 32'h1);
		secs(1, c);
		repeat (SEC / 2 + 3) @(negedge clock);
		rd_reg(4'h0);
		check({31'h0, d[1]}, 32'h1);
		@(posedge clock);
		seconds_write <= 1'b1;
		@(posedge clock);
		seconds_write <= 1'b0;
		rd_reg(4'h0);
		check({31'h0, d[1]}, 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			wr_reg(4'h0, {6'h0, cals[i], 16'h8008});
			secs(61, c);
			secs(60, c);
			check(32'(c), 32'(60 * SEC + int'($signed(cals[i]))));
		end
		// Turn the module off, then leave one idle cycle before the next access
		wr_reg(4'h0, 32'h0000_0008);
		@(posedge clock);
		rd_reg(4'h0);
		check(d & ~32'h6, 32'h0000_0008);
		@(posedge clock);
		resetn <= 1'b0;
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		rd_reg(4'h0);
		check(d, 32'h0);
		wrap_up;
	end
endmodule
